// ===== design/pdud_pkg.sv
`default_nettype none
package pdud_pkg;
  // clock and timing
  localparam int CLOCK_MHZ = 10;
  localparam int REF_RATE_KHZ = 250;
  localparam int MISSING_TIME_NS = 8000;
  localparam int MISSING_CYCLES = MISSING_TIME_NS * CLOCK_MHZ / 1000;
  localparam int LOCK_RANGE_HZ = 10000;
  localparam int WINDOW_US = 1000;
  localparam int WINDOW_CYCLES = WINDOW_US * CLOCK_MHZ;
  localparam int DIFF_LIMIT = LOCK_RANGE_HZ * WINDOW_US / 1000000;

  // divider decode: state reached 155 clocks after zero
  localparam logic [3:0] TC_HEX = 4'hf;
  localparam logic [3:0] TC_DEC = 4'h5;
  localparam logic [3:0] DEC_TOP = 4'h9;
  localparam logic [3:0] PRESET_IDLE = 4'hf;
  localparam logic [3:0] PRESET_START = 4'h0;
  localparam logic [3:0] PRESET_LAST = 4'h7;

  // register map, word indices taken from byte address bits 7:2
  localparam int AXI_AW = 8;
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_DIGITS = 6'h01;
  localparam logic [5:0] IDX_STATUS = 6'h02;
  localparam logic [5:0] IDX_DIFF = 6'h03;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] DIGITS_RESET = 8'h00;

  typedef struct packed {
    logic osc_prev;
    logic ref_prev;
    logic [3:0] dec;
    logic [3:0] hex;
    logic [3:0] preset;
    logic sample;
    logic ref_armed;
    logic sample_armed;
    logic ref_faster;
    logic sample_faster;
    logic diff_pulse;
    logic ramp_en;
    logic sample_sw;
    logic steer_high;
    logic steer_low;
    logic unlock;
    logic rate_over;
    logic ref_missing;
    logic sample_missing;
    logic [15:0] win_cnt;
    logic [7:0] diff_cnt;
    logic [7:0] diff_last;
    logic [7:0] ref_gap;
    logic [7:0] smp_gap;
    logic use_reg_digits;
    logic [7:0] digits;
    logic aw_full;
    logic [5:0] aw_idx;
    logic w_full;
    logic [7:0] w_data;
    logic w_strb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pdud_state_t;

  localparam pdud_state_t STATE_RESET = '{
    preset: 4'hf,
    digits: 8'h00,
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    default: '0
  };
endpackage
`default_nettype wire

// ===== design/pdud_top.sv
`default_nettype none
module pdud_top #(
  parameter int WINDOW_LEN = pdud_pkg::WINDOW_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic OSC_IN,
  input wire logic REF_IN,
  input wire logic [3:0] UNITS_BCD,
  input wire logic [3:0] TENS_BCD,
  output logic SAMPLE_OUT,
  output logic RAMP_ENABLE,
  output logic SAMPLE_SWITCH,
  output logic REF_FASTER,
  output logic SAMPLE_FASTER,
  output logic DIFF_PULSE,
  output logic UNLOCK,
  output logic STEER_HIGH,
  output logic STEER_LOW,
  input wire logic [pdud_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [pdud_pkg::AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  pdud_pkg::pdud_state_t s_q;
  pdud_pkg::pdud_state_t s_d;
  logic osc_fall;
  logic ref_fall;
  logic sample_fall;
  logic decode_tc;
  logic [7:0] sel_digits;
  logic win_end;

  function automatic logic trailing(input logic prev, input logic cur);
    trailing = prev & ~cur;
  endfunction

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hff) ? v : v + 8'h01;
  endfunction

  function automatic logic is_reg(input logic [pdud_pkg::AXI_AW-1:0] a);
    is_reg = (a[pdud_pkg::AXI_AW-1:4] == '0);
  endfunction

  always_comb
  begin
    s_d = s_q;
    s_d.osc_prev = OSC_IN;
    s_d.ref_prev = REF_IN;
    osc_fall = trailing(s_q.osc_prev, OSC_IN);
    ref_fall = trailing(s_q.ref_prev, REF_IN);
    // sample trailing edge is the preset stepping back to idle
    sample_fall = osc_fall && (s_q.preset == pdud_pkg::PRESET_LAST);
    // digits as BCD from pins unless software overrides
    sel_digits = s_q.use_reg_digits ? s_q.digits : {TENS_BCD, UNITS_BCD};
    // decode blocked until the preset is back at idle, stage d high again
    decode_tc = (s_q.hex == pdud_pkg::TC_HEX)
      && (s_q.dec == pdud_pkg::TC_DEC)
      && (s_q.preset == pdud_pkg::PRESET_IDLE);
    win_end = (s_q.win_cnt == 16'h0000);

    // divider
    if (osc_fall)
    begin
      if (decode_tc)
      begin
        s_d.preset = pdud_pkg::PRESET_START;
      end
      else if (s_q.preset != pdud_pkg::PRESET_IDLE)
      begin
        // absorb clocks, stages fill one per clock
        s_d.preset = {s_q.preset[2:0], 1'b1};
      end
      else
      begin
        if (s_q.dec == pdud_pkg::DEC_TOP)
        begin
          s_d.dec = 4'h0;
          s_d.hex = s_q.hex + 4'h1;
        end
        else
        begin
          s_d.dec = s_q.dec + 4'h1;
        end
      end
    end
    // loaded value is the complement of the ratio to 160
    if (!s_q.preset[2])
    begin
      s_d.hex = sel_digits[7:4];
    end
    if (!s_q.preset[1])
    begin
      s_d.dec = sel_digits[3:0];
    end
    s_d.sample = ~s_d.preset[3];

    // discriminator
    s_d.ref_faster = 1'b0;
    s_d.sample_faster = 1'b0;
    s_d.sample_sw = 1'b0;
    if (ref_fall && sample_fall)
    begin
      // coincident edges count as alternation
      s_d.ref_armed = 1'b1;
      s_d.sample_armed = 1'b0;
      s_d.sample_sw = s_q.ref_armed;
    end
    else if (ref_fall)
    begin
      // second reference with no sample between
      s_d.ref_faster = s_q.ref_armed;
      s_d.ref_armed = 1'b1;
      s_d.sample_armed = 1'b0;
    end
    else if (sample_fall)
    begin
      // mirrored path, exclusive by the branch order
      s_d.sample_faster = s_q.sample_armed;
      s_d.sample_armed = 1'b1;
      // clearing the ramp flop closes the sample switch
      s_d.sample_sw = s_q.ref_armed;
      s_d.ref_armed = 1'b0;
    end
    s_d.ramp_en = s_d.ref_armed;
    s_d.diff_pulse = s_q.ref_faster | s_q.sample_faster;

    s_d.ref_gap = ref_fall ? 8'h00 : sat_inc(s_q.ref_gap);
    s_d.smp_gap = sample_fall ? 8'h00 : sat_inc(s_q.smp_gap);
    // timeout is two periods of the reference rate
    s_d.ref_missing = (s_d.ref_gap >= 8'(pdud_pkg::MISSING_CYCLES));
    s_d.sample_missing = (s_d.smp_gap >= 8'(pdud_pkg::MISSING_CYCLES));

    // difference pulses counted over a fixed window
    if (win_end)
    begin
      s_d.win_cnt = 16'(WINDOW_LEN - 1);
      s_d.diff_last = s_q.diff_cnt;
      s_d.rate_over = (s_q.diff_cnt > 8'(pdud_pkg::DIFF_LIMIT));
      s_d.diff_cnt = {7'h00, s_q.diff_pulse};
    end
    else
    begin
      s_d.win_cnt = s_q.win_cnt - 16'h0001;
      s_d.diff_cnt = s_q.diff_pulse ? sat_inc(s_q.diff_cnt) : s_q.diff_cnt;
    end
    s_d.unlock = s_d.rate_over | s_d.ref_missing | s_d.sample_missing;

    if (!s_q.unlock)
    begin
      s_d.steer_high = 1'b0;
      s_d.steer_low = 1'b0;
    end
    else if (s_q.ref_faster)
    begin
      s_d.steer_high = 1'b1;
      s_d.steer_low = 1'b0;
    end
    else if (s_q.sample_faster)
    begin
      s_d.steer_high = 1'b0;
      s_d.steer_low = 1'b1;
    end

    // bus slave: write channels taken in either order
    if (S_AXI_AWVALID && s_q.awready)
    begin
      s_d.aw_full = 1'b1;
      s_d.aw_idx = is_reg(S_AXI_AWADDR) ? S_AXI_AWADDR[7:2] : 6'h3f;
    end
    if (S_AXI_WVALID && s_q.wready)
    begin
      s_d.w_full = 1'b1;
      s_d.w_data = S_AXI_WDATA[7:0];
      s_d.w_strb0 = S_AXI_WSTRB[0];
    end
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp = pdud_pkg::RESP_OKAY;
      case (s_q.aw_idx)
        pdud_pkg::IDX_CTRL:
        begin
          if (s_q.w_strb0)
          begin
            s_d.use_reg_digits = s_q.w_data[0];
          end
        end
        pdud_pkg::IDX_DIGITS:
        begin
          if (s_q.w_strb0)
          begin
            s_d.digits = s_q.w_data;
          end
        end
        // status and count are read only; writes ignored
        pdud_pkg::IDX_STATUS, pdud_pkg::IDX_DIFF:
        begin
          s_d.bresp = pdud_pkg::RESP_OKAY;
        end
        default:
        begin
          s_d.bresp = pdud_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && S_AXI_BREADY)
    begin
      s_d.bvalid = 1'b0;
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
    end
    s_d.awready = ~s_d.aw_full;
    s_d.wready = ~s_d.w_full;

    // read channel, answer one cycle after address
    if (S_AXI_ARVALID && s_q.arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = pdud_pkg::RESP_OKAY;
      s_d.rdata = 32'h00000000;
      case (is_reg(S_AXI_ARADDR) ? S_AXI_ARADDR[7:2] : 6'h3f)
        pdud_pkg::IDX_CTRL:
        begin
          s_d.rdata = {31'h00000000, s_q.use_reg_digits};
        end
        pdud_pkg::IDX_DIGITS:
        begin
          s_d.rdata = {24'h000000, s_q.digits};
        end
        pdud_pkg::IDX_STATUS:
        begin
          s_d.rdata = {26'h0000000, s_q.steer_low, s_q.steer_high,
            s_q.sample_missing, s_q.ref_missing, s_q.rate_over,
            s_q.unlock};
        end
        pdud_pkg::IDX_DIFF:
        begin
          s_d.rdata = {24'h000000, s_q.diff_last};
        end
        default:
        begin
          s_d.rresp = pdud_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_q.rvalid && S_AXI_RREADY)
    begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = ~s_d.rvalid;
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s_q <= pdud_pkg::STATE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign SAMPLE_OUT = s_q.sample;
  assign RAMP_ENABLE = s_q.ramp_en;
  assign SAMPLE_SWITCH = s_q.sample_sw;
  assign REF_FASTER = s_q.ref_faster;
  assign SAMPLE_FASTER = s_q.sample_faster;
  assign DIFF_PULSE = s_q.diff_pulse;
  assign UNLOCK = s_q.unlock;
  assign STEER_HIGH = s_q.steer_high;
  assign STEER_LOW = s_q.steer_low;
  assign S_AXI_AWREADY = s_q.awready;
  assign S_AXI_WREADY = s_q.wready;
  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_BRESP = s_q.bresp;
  assign S_AXI_ARREADY = s_q.arready;
  assign S_AXI_RVALID = s_q.rvalid;
  assign S_AXI_RDATA = s_q.rdata;
  assign S_AXI_RRESP = s_q.rresp;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  AST_PRESET_START: assert property (
    osc_fall && decode_tc |=> s_q.preset == 4'h0 && SAMPLE_OUT)
    else $error("preset did not start at terminal count");

  AST_PRESET_IDLE: assert property (
    osc_fall && s_q.preset == 4'h7 |=> s_q.preset == 4'hf && !SAMPLE_OUT)
    else $error("preset did not return idle after four clocks");

  AST_SAMPLE_STAGE: assert property (
    SAMPLE_OUT == !s_q.preset[3])
    else $error("sample output not the inverted last stage");

  AST_HEX_LOAD: assert property (
    s_q.preset == 4'h0 |=> s_q.hex == $past(sel_digits[7:4]))
    else $error("hex counter not loaded during preset");

  AST_HOLD: assert property (
    osc_fall && s_q.preset == 4'h7 |=> s_q.dec == $past(s_q.dec))
    else $error("main counter advanced during preset");

  AST_EXCLUSIVE: assert property (
    !(REF_FASTER && SAMPLE_FASTER))
    else $error("both faster outputs pulsed");

  AST_REF_FASTER: assert property (
    ref_fall && !sample_fall && s_q.ref_armed |=> REF_FASTER ##1 DIFF_PULSE)
    else $error("second reference not passed on");

  AST_RAMP: assert property (
    sample_fall && !ref_fall && s_q.ref_armed
      |=> SAMPLE_SWITCH && !RAMP_ENABLE ##1 !SAMPLE_SWITCH)
    else $error("ramp flop not cleared by sample");

  AST_MISSING: assert property (
    s_q.ref_missing || s_q.sample_missing |-> UNLOCK)
    else $error("missing pulses did not unlock");

  AST_RATE: assert property (
    win_end && s_q.diff_cnt > 8'(pdud_pkg::DIFF_LIMIT) |=> UNLOCK)
    else $error("rate difference did not unlock");

  AST_STEER_OFF: assert property (
    !UNLOCK |=> !STEER_HIGH && !STEER_LOW)
    else $error("steering present while locked");

  AST_STEER_DIR: assert property (
    UNLOCK && REF_FASTER |=> STEER_HIGH && !STEER_LOW)
    else $error("reference faster did not steer high");

endmodule // pdud_top
`default_nettype wire

// ===== sim/pdud_partner.sv
`default_nettype none
module pdud_partner (
  input wire logic clk,
  input wire logic osc_on,
  input wire logic ref_on,
  input wire logic [11:0] ref_per,
  input wire logic [7:0] ratio,
  output logic osc,
  output logic ref_pulse,
  output logic [3:0] units,
  output logic [3:0] tens
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] osc_ph = 2'h0;
  logic [11:0] ref_ph = 12'h000;
  logic [7:0] preload;
  initial osc = 1'b0;
  initial ref_pulse = 1'b0;
  assign preload = 8'ha0 - ratio;
  assign units = 4'(preload % 8'h0a);
  assign tens = 4'(preload / 8'h0a);
  always @(posedge clk)
  begin
    osc_ph <= osc_ph + 2'h1;
    // four clocks a period keeps us below half the system clock
    osc <= osc_on & osc_ph[1];
    ref_ph <= (ref_ph + 12'h001 >= ref_per) ? 12'h000 : ref_ph + 12'h001;
    // narrow pulse, two cycles wide
    ref_pulse <= ref_on & (ref_ph < 12'h002);
  end
endmodule // pdud_partner
`default_nettype wire

// ===== sim/pdud_top_tb.sv
`default_nettype none
module pdud_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] a_ctrl = {pdud_pkg::IDX_CTRL, 2'h0};
  localparam logic [7:0] a_dig = {pdud_pkg::IDX_DIGITS, 2'h0};
  localparam logic [7:0] a_stat = {pdud_pkg::IDX_STATUS, 2'h0};
  localparam logic [1:0] ok = pdud_pkg::RESP_OKAY;
  localparam logic [1:0] err = pdud_pkg::RESP_SLVERR;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc, ref_p, so, ramp, sw, rf, sf, dp, unl, sth, stl;
  logic awrdy, wrdy, bv, arrdy, rv;
  logic [3:0] units, tens;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic osc_on = 1'b0;
  logic ref_on = 1'b0;
  logic [11:0] ref_per = 12'h064;
  logic [7:0] ratio = 8'h3d;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bready = 1'b0;
  logic arv = 1'b0;
  logic rready = 1'b0;
  logic rf_q = 1'b0;
  logic sf_q = 1'b0;
  logic ramp_q = 1'b0;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int rf_cnt = 0;
  int sf_cnt = 0;
  int dp_cnt = 0;
  int both = 0;
  int bad = 0;
  int rel, rf0, sf0;

  always #50 clk = ~clk;

  pdud_top #(.WINDOW_LEN(200)) i_pdud_top (
    .CLOCK(clk), .RESET_N(rst_n), .OSC_IN(osc), .REF_IN(ref_p),
    .UNITS_BCD(units), .TENS_BCD(tens), .SAMPLE_OUT(so),
    .RAMP_ENABLE(ramp), .SAMPLE_SWITCH(sw), .REF_FASTER(rf),
    .SAMPLE_FASTER(sf), .DIFF_PULSE(dp), .UNLOCK(unl),
    .STEER_HIGH(sth), .STEER_LOW(stl),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rready)
  );

  pdud_partner i_pdud_partner (
    .clk(clk), .osc_on(osc_on), .ref_on(ref_on), .ref_per(ref_per),
    .ratio(ratio), .osc(osc), .ref_pulse(ref_p), .units(units),
    .tens(tens)
  );

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    rf_q <= rf;
    sf_q <= sf;
    ramp_q <= ramp;
    rf_cnt <= rf_cnt + int'(rf === 1'b1);
    sf_cnt <= sf_cnt + int'(sf === 1'b1);
    dp_cnt <= dp_cnt + int'(dp === 1'b1);
    both <= both + int'(rf === 1'b1 && sf === 1'b1);
    // diff pulse trails a faster pulse; switch only closes an armed ramp
    bad <= bad + int'(dp === 1'b1 && !(rf_q | sf_q))
      + int'(sw === 1'b1 && ramp_q !== 1'b1);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic done;
    logic [1:0] r;
    done = 1'b0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    // only the watchdog ends a stalled write
    while (!done)
    begin
      @(posedge clk);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv === 1'b1)
      begin
        r = bresp;
        done = 1'b1;
      end
    end
    bready <= 1'b0;
    @(posedge clk);
    chk(32'(r), 32'(er));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m, input logic [1:0] er);
    logic done;
    logic [1:0] r;
    logic [31:0] d;
    done = 1'b0;
    r = 2'h3;
    d = 32'hffffffff;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (arv && arrdy) arv <= 1'b0;
      if (rv === 1'b1)
      begin
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
    end
    rready <= 1'b0;
    @(posedge clk);
    chk(d & m, e);
    chk(32'(r), 32'(er));
  endtask

  task automatic wait_so(input logic v);
    while (so !== v)
    begin
      @(posedge clk);
    end
  endtask

  // new digits go in on the next preset, so time the cycle after it
  task automatic run_div(input logic [7:0] nset, input int nexp);
    int t0;
    wait_so(1'b0);
    ratio <= nset;
    wait_so(1'b1);
    t0 = cyc;
    wait_so(1'b0);
    chk(32'(cyc - t0), 32'h10);
    wait_so(1'b1);
    chk(32'(cyc - t0), 32'(4 * nexp));
  endtask

  task automatic run_disc(input logic [11:0] per);
    ref_per <= per;
    repeat (600) @(posedge clk);
    rf0 = rf_cnt;
    sf0 = sf_cnt;
    repeat (2500) @(posedge clk);
  endtask

  // slow test rates trip the missing detectors between pulses, so
  // steering is only certain right after a faster pulse
  task automatic steer_chk(input logic hi);
    while ((hi ? rf : sf) !== 1'b1)
    begin
      @(posedge clk);
    end
    chk(32'(unl), 32'h1);
    @(posedge clk);
    chk(32'({sth, stl}), 32'({hi, ~hi}));
  endtask

  initial
  begin
    #4000000;
    error_cnt++;
    test_done();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rel = cyc;
    @(posedge clk);
    chk(32'({so, rf, sf, dp, unl, sth, stl, awrdy, wrdy, arrdy, bv, rv}),
        32'h1c);
    axi_rd(a_dig, 32'h0, 32'hffffffff, ok);
    axi_rd(a_ctrl, 32'h0, 32'hffffffff, ok);
    axi_rd(8'h10, 32'h0, 32'hffffffff, err);
    axi_wr(8'h10, 32'h1, err);
    axi_wr(a_stat, 32'h0, ok);
    while (cyc < rel + 65) @(posedge clk);
    chk(32'(unl), 32'h0);
    while (cyc < rel + 95) @(posedge clk);
    chk(32'(unl), 32'h1);
    axi_rd(a_stat, 32'h0d, 32'h0d, ok);
    osc_on <= 1'b1;
    run_div(8'h3d, 61);
    run_div(8'ha0, 160);
    run_div(8'h64, 100);
    axi_wr(a_dig, 32'h45, ok);
    axi_wr(a_ctrl, 32'h1, ok);
    axi_rd(a_dig, 32'h45, 32'hffffffff, ok);
    run_div(8'h3d, 115);
    axi_wr(a_ctrl, 32'h0, ok);
    run_div(8'h3d, 61);
    ref_on <= 1'b1;
    run_disc(12'h064);
    chk(32'(rf_cnt > rf0), 32'h1);
    chk(32'(sf_cnt - sf0), 32'h0);
    steer_chk(1'b1);
    run_disc(12'h3e8);
    chk(32'(sf_cnt > sf0), 32'h1);
    chk(32'(rf_cnt - rf0), 32'h0);
    steer_chk(1'b0);
    // reference every 12 clocks: well over ten difference pulses a window
    run_disc(12'h00c);
    chk(32'(rf_cnt > rf0), 32'h1);
    axi_rd(a_stat, 32'h03, 32'h03, ok);
    ref_on <= 1'b0;
    osc_on <= 1'b0;
    repeat (20) @(posedge clk);
    chk(32'(both), 32'h0);
    chk(32'(dp_cnt), 32'(rf_cnt + sf_cnt));
    chk(32'(bad), 32'h0);
    test_done();
  end
endmodule // pdud_top_tb
`default_nettype wire
